// file: verilog/scfm_config_master.v
// Purpose: Boot-time master that loads configuration from a serial flash.
// Assumes: Pins reach the block raw and are synchronised here; the block
//          makes the serial clock itself by dividing the system clock.
// Notes:   Open-drain pins: output enable low means pulling the pin low.
`include "scfm_defines.vh"
module scfm_config_master #(
	parameter [23:0] CONFIG_BITS  = `SCFM_CONFIG_BITS,
	parameter [15:0] CLEAR_CYCLES = `SCFM_CLEAR_CYCLES
) (
	// Clock and reset
	input  wire       clock,
	input  wire       reset_n,
	// Program request pin
	input  wire       program_request_n,
	// Open-drain initialisation indicator
	input  wire       init_in,
	output wire       init_out,
	output reg        init_oe_n,
	// Open-drain done indicator
	input  wire       done_in,
	output wire       done_out,
	output reg        done_oe_n,
	// Strap pins
	input  wire [2:0] mode_straps,
	input  wire [2:0] flash_variant_straps,
	input  wire       pullup_disable_strap,
	// Flash link
	output reg        flash_select_n,
	output reg        config_serial_clock,
	output reg        flash_mosi,
	input  wire       config_data_in,
	// Daisy-chain output
	output reg        chain_data_out,
	// User side
	output reg        pullup_enable,
	output reg        strap_pins_released,
	output reg  [7:0] config_byte,
	output reg        config_byte_valid,
	output reg        crc_error,
	output reg        variant_error
);
	localparam [3:0] ST_CLEAR  = 4'h0;
	localparam [3:0] ST_WAIT   = 4'h1;
	localparam [3:0] ST_DECIDE = 4'h2;
	localparam [3:0] ST_SEND   = 4'h3;
	localparam [3:0] ST_READ   = 4'h4;
	localparam [3:0] ST_FINISH = 4'h5;
	localparam [3:0] ST_DONE   = 4'h6;
	localparam [3:0] ST_USER   = 4'h7;
	localparam [3:0] ST_ERROR  = 4'h8;
	localparam [3:0] ST_HALT   = 4'h9;
	localparam [4:0] HALF_M1   = `SCFM_SCLK_HALF - 5'h01;
	// Two-stage synchronisers; the data lane is read only inside frames
	wire [10:0] pin_raw = {config_data_in, program_request_n, init_in, done_in,
	                       mode_straps, flash_variant_straps, pullup_disable_strap};
	reg  [10:0] pin_meta;
	reg  [10:0] pin_sync;
	genvar g;
	generate
		for (g = 0; g < 11; g = g + 1) begin : g_sync
			always @(posedge clock) begin
				if (!reset_n) begin
					pin_meta[g] <= 1'b1;
					pin_sync[g] <= 1'b1;
				end else begin
					pin_meta[g] <= pin_raw[g];
					pin_sync[g] <= pin_meta[g];
				end
			end
		end
	endgenerate
	wire       din_sync  = pin_sync[10];
	wire       prog_n_s  = pin_sync[9];
	wire       init_s    = pin_sync[8];
	wire       done_s    = pin_sync[7];
	wire [2:0] mode_s    = pin_sync[6:4];
	wire [2:0] variant_s = pin_sync[3:1];
	wire       pud_s     = pin_sync[0];
	reg  [3:0]  state;
	reg  [15:0] clear_cnt;
	reg  [4:0]  div_cnt;
	reg  [23:0] bit_cnt;
	reg  [55:0] hdr_shift;
	reg  [23:0] hdr_last;
	reg  [2:0]  mode_cap;
	reg  [2:0]  variant_cap;
	reg         init_prev;
	reg  [7:0]  byte_shift;
	wire [15:0] crc;
	wire tick     = (div_cnt == HALF_M1);
	wire rise     = tick && !config_serial_clock;
	wire fall     = tick && config_serial_clock;
	wire sclk_run = (state == ST_SEND) || (state == ST_READ) ||
	                ((state == ST_FINISH) && config_serial_clock);
	wire take_bit = (state == ST_READ) && rise;
	// Command and dummy count chosen by the captured variant
	reg [7:0] sel_cmd;
	reg [1:0] sel_dummy;
	reg       sel_ok;
	always @* begin
		sel_cmd   = `SCFM_CMD_READ;
		sel_dummy = `SCFM_DUMMY_READ;
		sel_ok    = 1'b1;
		case (variant_cap)
			`SCFM_VARIANT_FAST: begin
				sel_cmd   = `SCFM_CMD_FAST;
				sel_dummy = `SCFM_DUMMY_FAST;
			end
			`SCFM_VARIANT_ARRAY: begin
				sel_cmd   = `SCFM_CMD_ARRAY;
				sel_dummy = `SCFM_DUMMY_ARRAY;
			end
			`SCFM_VARIANT_READ: sel_ok = 1'b1;
			default:            sel_ok = 1'b0;
		endcase
	end
	scfm_crc16 u_crc (
		.clock     (clock),
		.reset_n   (reset_n),
		.clear     (state == ST_DECIDE),
		.bit_valid (take_bit),
		.bit_in    (din_sync),
		.crc       (crc)
	);
	// Open-drain pins only ever pull low
	assign init_out = 1'b0;
	assign done_out = 1'b0;
	// Serial clock divider; it idles low between frames
	always @(posedge clock) begin
		if (!reset_n || !sclk_run) begin
			div_cnt <= 5'h00;
		end else if (tick) begin
			div_cnt <= 5'h00;
		end else begin
			div_cnt <= div_cnt + 5'h01;
		end
	end
	always @(posedge clock) begin
		if (!reset_n) begin
			state               <= ST_CLEAR;
			clear_cnt           <= 16'h0000;
			bit_cnt             <= 24'h000000;
			hdr_shift           <= 56'h0;
			hdr_last            <= 24'h000000;
			mode_cap            <= 3'h0;
			variant_cap         <= 3'h0;
			init_prev           <= 1'b0;
			byte_shift          <= 8'h00;
			init_oe_n           <= 1'b0;
			done_oe_n           <= 1'b0;
			flash_select_n      <= 1'b1;
			config_serial_clock <= 1'b0;
			flash_mosi          <= 1'b0;
			chain_data_out      <= 1'b0;
			pullup_enable       <= 1'b0;
			strap_pins_released <= 1'b0;
			config_byte         <= 8'h00;
			config_byte_valid   <= 1'b0;
			crc_error           <= 1'b0;
			variant_error       <= 1'b0;
		end else begin
			config_byte_valid <= 1'b0;
			init_prev         <= init_s;
			// Pull-ups follow the strap only until done releases the pins
			pullup_enable     <= !strap_pins_released && !pud_s;
			if (sclk_run && tick) begin
				config_serial_clock <= !config_serial_clock;
			end
			case (state)
				ST_CLEAR: begin
					init_oe_n <= 1'b0;
					done_oe_n <= 1'b0;
					if (clear_cnt == CLEAR_CYCLES - 16'h0001) begin
						init_oe_n <= 1'b1;
						state     <= ST_WAIT;
					end else begin
						clear_cnt <= clear_cnt + 16'h0001;
					end
				end
				ST_WAIT: begin
					// The board may hold init low until the flash is awake
					if (init_s && !init_prev) begin
						mode_cap    <= mode_s;
						variant_cap <= variant_s;
						state       <= ST_DECIDE;
					end
				end
				ST_DECIDE: begin
					if (mode_cap != `SCFM_MODE_SPI) begin
						state <= ST_HALT;
					end else if (!sel_ok) begin
						variant_error <= 1'b1;
						init_oe_n     <= 1'b0;
						state         <= ST_ERROR;
					end else begin
						hdr_shift      <= {sel_cmd, `SCFM_START_ADDR, 24'h000000};
						hdr_last       <= {18'h0, `SCFM_HDR_BITS + {1'b0, sel_dummy, 3'h0}}
						                  - 24'h000001;
						flash_mosi     <= sel_cmd[7];
						flash_select_n <= 1'b0;
						bit_cnt        <= 24'h000000;
						state          <= ST_SEND;
					end
				end
				ST_SEND: begin
					// Flash samples on the rise, so MOSI moves on the fall
					if (fall) begin
						if (bit_cnt == hdr_last) begin
							bit_cnt <= 24'h000000;
							state   <= ST_READ;
						end else begin
							hdr_shift  <= {hdr_shift[54:0], 1'b0};
							flash_mosi <= hdr_shift[54];
							bit_cnt    <= bit_cnt + 24'h000001;
						end
					end
				end
				ST_READ: begin
					if (take_bit) begin
						byte_shift     <= {byte_shift[6:0], din_sync};
						chain_data_out <= din_sync;
						if (bit_cnt[2:0] == 3'h7) begin
							config_byte       <= {byte_shift[6:0], din_sync};
							config_byte_valid <= 1'b1;
						end
						if (bit_cnt == CONFIG_BITS - 24'h000001) begin
							state <= ST_FINISH;
						end else begin
							bit_cnt <= bit_cnt + 24'h000001;
						end
					end
				end
				ST_FINISH: begin
					// Let the clock fall before the select rises
					if (!config_serial_clock) begin
						flash_select_n <= 1'b1;
						flash_mosi     <= 1'b0;
						if (crc != 16'h0000) begin
							crc_error <= 1'b1;
							init_oe_n <= 1'b0;
							state     <= ST_ERROR;
						end else begin
							done_oe_n <= 1'b1;
							state     <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					// A board that holds done low keeps the straps owned here
					if (done_s) begin
						strap_pins_released <= 1'b1;
						state               <= ST_USER;
					end
				end
				ST_USER, ST_ERROR, ST_HALT: begin
				end
				default: begin
					state <= ST_CLEAR;
				end
			endcase
			// Program request restarts from memory clearing
			if (!prog_n_s) begin
				state               <= ST_CLEAR;
				clear_cnt           <= 16'h0000;
				init_oe_n           <= 1'b0;
				done_oe_n           <= 1'b0;
				flash_select_n      <= 1'b1;
				config_serial_clock <= 1'b0;
				flash_mosi          <= 1'b0;
				strap_pins_released <= 1'b0;
				crc_error           <= 1'b0;
				variant_error       <= 1'b0;
			end
		end
	end
	// Only select, clock, MOSI and data in reach the flash; no write-protect,
	// hold, reset or ready/busy port exists.
endmodule

// file: verilog/scfm_defines.vh
// Purpose: Shared constants of the serial flash configuration master.
// Assumes: 200 MHz system clock.
// Notes:   Definitions only.
`ifndef SCFM_DEFINES_VH
`define SCFM_DEFINES_VH

// Mode strap code that selects serial flash loading
`define SCFM_MODE_SPI       3'h1

// Variant strap codes
`define SCFM_VARIANT_FAST   3'h7
`define SCFM_VARIANT_READ   3'h5
`define SCFM_VARIANT_ARRAY  3'h6

// Flash read commands per variant
`define SCFM_CMD_FAST       8'h0b
`define SCFM_CMD_READ       8'h03
`define SCFM_CMD_ARRAY      8'he8

// Dummy byte counts per variant
`define SCFM_DUMMY_FAST     2'h1
`define SCFM_DUMMY_READ     2'h0
`define SCFM_DUMMY_ARRAY    2'h3

// First flash address read
`define SCFM_START_ADDR     24'h000000

// Command plus address length in bits
`define SCFM_HDR_BITS       6'h20

// Serial clock half period in system cycles: 200 MHz down to 6.25 MHz
`define SCFM_SCLK_HALF      5'h10

// Memory clearing length in system cycles
`define SCFM_CLEAR_CYCLES   16'h0040

// Default configuration stream length in bits, trailing check word included
`define SCFM_CONFIG_BITS    24'h002000

// Check word polynomial and start value
`define SCFM_CRC_POLY       16'h1021
`define SCFM_CRC_INIT       16'h0000

`endif

// file: verilog/scfm_crc16.v
// Purpose: Bit-serial check word over the incoming configuration stream.
// Assumes: One bit per bit_valid; clear restarts the sum.
// Notes:   With the check word appended, a clean stream leaves zero.
`include "scfm_defines.vh"

module scfm_crc16 (
	// Clock and reset
	input  wire        clock,
	input  wire        reset_n,
	// Control
	input  wire        clear,
	input  wire        bit_valid,
	input  wire        bit_in,
	// Result
	output reg  [15:0] crc
);

	wire feedback = crc[15] ^ bit_in;

	always @(posedge clock) begin
		if (!reset_n || clear) begin
			crc <= `SCFM_CRC_INIT;
		end else if (bit_valid) begin
			crc <= {crc[14:0], 1'b0} ^ (feedback ? `SCFM_CRC_POLY : 16'h0000);
		end
	end

endmodule

// file: bench/scfm_chk.sv
// Purpose: Port-level checks of the configuration master.
// Assumes: Open-drain wires see pull-ups in the bench.
// Notes:   Attached by bind below.
module scfm_chk (
	input wire clock,
	input wire reset_n,
	input wire init_oe_n,
	input wire done_oe_n,
	input wire done_in,
	input wire flash_select_n,
	input wire config_serial_clock,
	input wire flash_mosi,
	input wire config_byte_valid,
	input wire pullup_enable,
	input wire strap_pins_released,
	input wire crc_error,
	input wire variant_error
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_cs_init; !init_oe_n |-> flash_select_n; endproperty
	a_cs_init: assert property (p_cs_init) else $error("select while init low");
	property p_idle; flash_select_n |-> !config_serial_clock; endproperty
	a_idle: assert property (p_idle) else $error("clock outside frame");
	property p_half; $rose(config_serial_clock) |->
		config_serial_clock[*8] ##1 config_serial_clock[*8] ##1 !config_serial_clock; endproperty
	a_half: assert property (p_half) else $error("clock high time");
	property p_mosi; config_serial_clock |-> $stable(flash_mosi); endproperty
	a_mosi: assert property (p_mosi) else $error("mosi moved while high");
	property p_byte; config_byte_valid |-> !flash_select_n; endproperty
	a_byte: assert property (p_byte) else $error("byte outside frame");
	property p_pull; strap_pins_released |=> !pullup_enable; endproperty
	a_pull: assert property (p_pull) else $error("pull-ups after release");
	property p_rel; $rose(done_in) |-> ##[1:4] strap_pins_released; endproperty
	a_rel: assert property (p_rel) else $error("straps not released");
	property p_crc; $rose(crc_error) |-> ##[0:1] !init_oe_n; endproperty
	a_crc: assert property (p_crc) else $error("init not pulled");
	property p_var; $rose(variant_error) |-> flash_select_n ##[0:1] !init_oe_n; endproperty
	a_var: assert property (p_var) else $error("reserved variant accepted");
	property p_done; $rose(done_oe_n) |-> flash_select_n && !crc_error; endproperty
	a_done: assert property (p_done) else $error("done too early");
	c_byte: cover property (config_byte_valid);
	c_done: cover property ($rose(done_oe_n));
	c_crc: cover property ($rose(crc_error));
endmodule

bind scfm_config_master scfm_chk chk_u (.clock(clock), .reset_n(reset_n),
	.init_oe_n(init_oe_n), .done_oe_n(done_oe_n), .done_in(done_in),
	.flash_select_n(flash_select_n), .config_serial_clock(config_serial_clock),
	.flash_mosi(flash_mosi), .config_byte_valid(config_byte_valid),
	.pullup_enable(pullup_enable), .strap_pins_released(strap_pins_released),
	.crc_error(crc_error), .variant_error(variant_error));

// file: bench/scfm_flash_model.sv
// Purpose: Serial flash seen from the link, mode 0.
// Assumes: Header is 32 bits, then dum zero bytes.
// Notes:   Released output toggles so stale data never looks valid.
module scfm_flash_model (
	// Link
	input  wire        sel_n,
	input  wire        sclk,
	input  wire        si,
	output logic       so,
	// Bench side
	input  wire [1:0]  dum,
	input  wire [47:0] stream,
	output logic [31:0] hdr
);
	timeunit 1ns;
	timeprecision 1ps;
	int  cnt = 0;
	int  idx;
	wire hold_n = 1'b1;
	initial so = 1'b0;
	always @(posedge sclk or posedge sel_n) begin
		if (sel_n)
			cnt <= 0;
		else begin
			if (cnt < 32)
				hdr <= {hdr[30:0], si};
			cnt <= cnt + 1;
		end
	end
	always @(negedge sclk or posedge sel_n) begin
		idx = cnt - 32 - 8 * dum;
		if (sel_n || !hold_n || idx < 0 || idx > 47)
			so <= ~so;
		else
			so <= stream[47 - idx];
	end
endmodule

// file: bench/testbench.sv
// Purpose: Loads through each variant, a bad check word and refusals.
// Assumes: Restart by program request between loads.
// Notes:   Short stream and clear length keep the run brief.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 0, reset_n = 0, program_request_n = 1, pull_strap = 0;
	logic [2:0]  mode = 3'h1, variant = 3'h7;
	logic [1:0]  dum = 2'h0;
	logic [47:0] stream = 48'h0, s;
	logic [7:0]  e;
	logic [7:0]  q[$];
	wire         init_out, init_oe_n, done_out, done_oe_n, sel_n, sclk, mosi, din;
	wire         chain, pullup_enable, released, crc_error, variant_error, bvalid;
	wire [7:0]   cbyte;
	wire [31:0]  hdr;
	wire         init_w = init_oe_n ? 1'b1 : init_out;
	wire         done_w = done_oe_n ? 1'b1 : done_out;
	int          fails = 0, n_checks = 0, i, k;
	logic [2:0]  vr_t[6] = '{3'h7, 3'h5, 3'h6, 3'h7, 3'h3, 3'h7};
	logic [2:0]  md_t[6] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0};
	logic [7:0]  cm_t[6] = '{8'h0b, 8'h03, 8'he8, 8'h0b, 8'h00, 8'h00};
	logic [1:0]  dm_t[6] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h0, 2'h0};
	always #2.5 clock = ~clock;
	scfm_config_master #(.CONFIG_BITS(24'h30), .CLEAR_CYCLES(16'h4)) dut_u (
		.clock(clock), .reset_n(reset_n), .program_request_n(program_request_n),
		.init_in(init_w), .init_out(init_out), .init_oe_n(init_oe_n),
		.done_in(done_w), .done_out(done_out), .done_oe_n(done_oe_n),
		.mode_straps(mode), .flash_variant_straps(variant), .pullup_disable_strap(pull_strap),
		.flash_select_n(sel_n), .config_serial_clock(sclk), .flash_mosi(mosi),
		.config_data_in(din), .chain_data_out(chain), .pullup_enable(pullup_enable),
		.strap_pins_released(released), .config_byte(cbyte), .config_byte_valid(bvalid),
		.crc_error(crc_error), .variant_error(variant_error));
	scfm_flash_model flash_u (.sel_n(sel_n), .sclk(sclk), .si(mosi), .so(din),
		.dum(dum), .stream(stream), .hdr(hdr));
	function automatic logic [15:0] crc(input logic [31:0] d);
		logic [15:0] r;
		r = 16'h0;
		for (int j = 31; j >= 0; j--)
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[j]) ? 16'h1021 : 16'h0);
		return r;
	endfunction
	task results;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Queue head is the oldest byte still owed by the flash
	always @(posedge clock) begin
		if (bvalid === 1'b1) begin
			`CHK(q.size() > 0, 1'b1)
			e = q.size() ? q.pop_front() : 8'h00;
			`CHK(cbyte, e)
		end
	end
	initial begin
		void'($urandom(82));
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		for (k = 0; k < 6; k++) begin
			@(posedge clock);
			s = {$urandom, 16'h0};
			s[15:0] = crc(s[47:16]) ^ (k == 3);
			stream <= s;
			program_request_n <= 1'b0;
			mode <= md_t[k];
			variant <= vr_t[k];
			pull_strap <= k[0];
			dum <= dm_t[k];
			if (k < 4)
				for (i = 5; i >= 0; i--)
					q.push_back(s[8 * i +: 8]);
			repeat (8) @(posedge clock);
			program_request_n <= 1'b1;
			for (i = 0; i < 400 && sel_n !== 1'b0; i++)
				@(posedge clock);
			`CHK(i == 400, k > 3)
			if (k < 4) `CHK(pullup_enable, !pull_strap)
			for (i = 0; i < 5000 && done_oe_n !== 1'b1 && crc_error !== 1'b1
				&& variant_error !== 1'b1; i++)
				@(posedge clock);
			if ((i == 5000) != (k == 5)) begin
				fails++;
				results();
			end
			repeat (8) @(posedge clock);
			`CHK(done_oe_n, k < 3)
			`CHK(crc_error, k == 3)
			`CHK(variant_error, k == 4)
			`CHK(q.size(), 0)
			if (k < 4) `CHK(hdr, {cm_t[k], 24'h0})
			if (k < 3) `CHK(released, 1'b1)
			if (k < 3) `CHK(chain, s[0])
			if (k == 5) `CHK(sel_n, 1'b1)
		end
		results();
	end
endmodule
